// >>> hdl/afepc_top.sv
`include "afepc_defines.svh"
module afepc_top
    import afepc_pkg::*;
#(
    parameter int N = `AFEPC_CELLS
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Supply monitor comparators (asynchronous)
    input  wire logic         supply_above_por_i,
    input  wire logic         supply_below_shut_i,
    // Host-written control bits (same clock)
    input  wire logic         ctl_we_i,
    input  wire logic [3:0]   oc_trip_level_sel_i,
    input  wire logic         oc_direction_sel_i,
    input  wire logic [1:0]   cell_out_source_sel_i,
    input  wire logic [2:0]   cell_sel_i,
    input  wire logic [N-1:0] bleed_control_reg_i,
    input  wire logic         cell_xlat_on_i,
    input  wire logic         cur_amp_on_i,
    input  wire logic         ref_on_i,
    input  wire logic         oc_comp_on_i,
    input  wire logic         thermistor_bias_on_i,
    input  wire logic         sleep_i,
    input  wire logic         sleep_override_i,
    input  wire logic         por_flag_we_i,
    input  wire logic         por_flag_wdata_i,
    // Analog sense inputs (asynchronous)
    input  wire logic         oc_pos_over_i,
    input  wire logic         oc_neg_over_i,
    input  wire logic         regulator_discharged_i,
    input  wire logic         alert_pin_i,
    // Analog control outputs
    output logic [15:0]       oc_trip_mv_o,
    output logic              oc_direction_o,
    output logic              alert_o,
    output logic              alert_oe_o,
    output logic              alert_status_o,
    output logic              thermistor_bias_out_o,
    output afepc_mux_t        cell_measure_out_o,
    output logic [N-1:0]      bleed_switch_on_o,
    output afepc_enables_t    enables_o,
    output logic              regulator_on_o,
    output logic              regulator_pulldown_o,
    output logic              wake_armed_o,
    output logic              por_flag_o,
    output logic              powered_o
);
    ////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    localparam int NS = 5;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_ff;
    logic [NS-1:0] s2_ff;
    logic [NS-1:0] s3_ff;
    logic [NS-1:0] q_ff;
    assign raw = {supply_above_por_i, supply_below_shut_i, oc_pos_over_i,
                  oc_neg_over_i, regulator_discharged_i};
    logic [1:0] xs1_ff;
    logic [1:0] xs2_ff;
    logic [1:0] xs3_ff;
    logic [1:0] xq_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            q_ff   <= '0;
            xs1_ff <= '0;
            xs2_ff <= '0;
            xs3_ff <= '0;
            xq_ff  <= '0;
        end else begin
            s1_ff  <= raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            q_ff   <= (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
            xs1_ff <= {alert_pin_i, 1'b0};
            xs2_ff <= xs1_ff;
            xs3_ff <= xs2_ff;
            xq_ff  <= (xs2_ff & xs3_ff) | (xq_ff & (xs2_ff | xs3_ff));
        end
    end
    logic above_por;
    logic below_shut;
    logic pos_over;
    logic neg_over;
    logic reg_dis;
    logic alert_high;
    assign above_por  = q_ff[4];
    assign below_shut = q_ff[3];
    assign pos_over   = q_ff[2];
    assign neg_over   = q_ff[1];
    assign reg_dis    = q_ff[0];
    assign alert_high = xq_ff[1];

    ////////////////////////////////////////////////////////////////////
    // Power state machine
    afepc_state_t state_ff;
    afepc_state_t nxt_state;
    logic         por_evt;
    logic         sleep_ff;
    logic         ovr_ff;
    always_comb begin
        nxt_state = state_ff;
        por_evt   = 1'b0;
        unique case (state_ff)
            AFEPC_OFF: begin
                if (above_por && !below_shut) begin
                    nxt_state = AFEPC_RUN;
                    por_evt   = 1'b1;
                end
            end
            AFEPC_RUN: begin
                if (below_shut) begin
                    nxt_state = AFEPC_OFF;
                end else if (sleep_ff && !ovr_ff) begin
                    nxt_state = AFEPC_SLEEP_DRAIN;
                end
            end
            AFEPC_SLEEP_DRAIN: begin
                if (ovr_ff) begin
                    nxt_state = AFEPC_RUN;
                end else if (reg_dis) begin
                    nxt_state = AFEPC_SLEEP_ARMED;
                end
            end
            AFEPC_SLEEP_ARMED: begin
                if (alert_high) begin
                    nxt_state = AFEPC_RUN;
                    por_evt   = 1'b1;
                end
            end
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= AFEPC_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end
    logic run;
    logic defaults;
    assign run      = (state_ff == AFEPC_RUN);
    // Leaving the off state or waking reloads defaults, like a power-on reset
    assign defaults = (state_ff == AFEPC_OFF) || por_evt;

    ////////////////////////////////////////////////////////////////////
    // Volatile control registers
    logic [3:0]     trip_ff;
    logic           dir_ff;
    logic [1:0]     src_ff;
    logic [2:0]     csel_ff;
    logic [N-1:0]   bleed_ff;
    afepc_enables_t en_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_ff  <= `AFEPC_RST_TRIP_SEL;
            dir_ff   <= 1'b0;
            src_ff   <= `AFEPC_RST_SRC_SEL;
            csel_ff  <= `AFEPC_RST_CELL_SEL;
            bleed_ff <= `AFEPC_RST_BLEED;
            en_ff    <= `AFEPC_RST_ENABLES;
            sleep_ff <= 1'b0;
            ovr_ff   <= 1'b0;
        end else if (defaults) begin
            trip_ff  <= `AFEPC_RST_TRIP_SEL;
            dir_ff   <= 1'b0;
            src_ff   <= `AFEPC_RST_SRC_SEL;
            csel_ff  <= `AFEPC_RST_CELL_SEL;
            bleed_ff <= `AFEPC_RST_BLEED;
            en_ff    <= `AFEPC_RST_ENABLES;
            sleep_ff <= 1'b0;
            ovr_ff   <= 1'b0;
        end else if (ctl_we_i && run) begin
            trip_ff  <= oc_trip_level_sel_i;
            dir_ff   <= oc_direction_sel_i;
            src_ff   <= cell_out_source_sel_i;
            csel_ff  <= cell_sel_i;
            bleed_ff <= bleed_control_reg_i;
            en_ff    <= {cell_xlat_on_i, cur_amp_on_i, ref_on_i,
                         oc_comp_on_i, thermistor_bias_on_i};
            sleep_ff <= sleep_i & ~sleep_override_i;
            ovr_ff   <= sleep_override_i;
        end else if (ctl_we_i) begin
            // Only the override is heard while draining; it cancels sleep
            ovr_ff   <= sleep_override_i;
            sleep_ff <= sleep_ff & ~sleep_override_i;
        end else if (!run) begin
            sleep_ff <= sleep_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power-on flag: set wins over a same-cycle clear
    logic por_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            por_ff <= 1'b0;
        end else if (por_evt) begin
            por_ff <= 1'b1;
        end else if (state_ff == AFEPC_OFF) begin
            por_ff <= 1'b0;
        end else if (por_flag_we_i && !por_flag_wdata_i) begin
            por_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Overcurrent comparator and alert
    logic over;
    logic alert_ff;
    logic [15:0] trip_mv_ff;
    assign over = dir_ff ? neg_over : pos_over;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alert_ff   <= 1'b0;
            trip_mv_ff <= `AFEPC_TRIP_MIN_MV;
        end else begin
            alert_ff   <= run & en_ff.oc_comp_on & over;
            // Sixteen codes span 25 mV to 400 mV in 25 mV steps
            trip_mv_ff <= `AFEPC_TRIP_MIN_MV
                        + 16'(trip_ff) * `AFEPC_TRIP_STEP_MV;
        end
    end
    assign oc_trip_mv_o   = trip_mv_ff;
    assign oc_direction_o = dir_ff;
    // Open drain: drive low only, which signals the alert to the host
    assign alert_o        = 1'b0;
    assign alert_oe_o     = alert_ff;
    // Live status; there is no stored copy for a write to disturb
    assign alert_status_o = alert_ff;

    ////////////////////////////////////////////////////////////////////
    // Output mux, bias, bleed switches, power controls
    afepc_mux_t mux_ff;
    logic [N-1:0] bleed_sw;
    logic [N-1:0] bleed_out_ff;
    afepc_bleed #(
        .N (N)
    ) u_bleed (
        .req_i (bleed_ff),
        .sw_o  (bleed_sw)
    );
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mux_ff       <= '0;
            bleed_out_ff <= '0;
        end else begin
            mux_ff.cell_out_source_sel <= src_ff;
            mux_ff.cell_sel            <= csel_ff;
            mux_ff.temp_sel            <= (src_ff == `AFEPC_SRC_CELL)
                                       && (csel_ff == `AFEPC_TEMP_CELL_SEL);
            bleed_out_ff               <= run ? bleed_sw : '0;
        end
    end
    assign cell_measure_out_o    = mux_ff;
    assign bleed_switch_on_o     = bleed_out_ff;
    assign enables_o             = run ? en_ff : '0;
    assign thermistor_bias_out_o = run & en_ff.thermistor_bias_on;
    assign regulator_on_o        = run;
    assign regulator_pulldown_o  = (state_ff == AFEPC_SLEEP_DRAIN)
                                || (state_ff == AFEPC_SLEEP_ARMED);
    assign wake_armed_o          = (state_ff == AFEPC_SLEEP_ARMED);
    assign por_flag_o            = por_ff;
    assign powered_o             = run;
endmodule : afepc_top

// >>> hdl/afepc_defines.svh
`ifndef AFEPC_DEFINES_SVH
`define AFEPC_DEFINES_SVH
`define AFEPC_TRIP_MIN_MV     16'd25
`define AFEPC_TRIP_MAX_MV     16'd400
`define AFEPC_TRIP_STEP_MV    16'd25
`define AFEPC_CELLS           6
`define AFEPC_TEMP_CELL_SEL   3'h6
`define AFEPC_SRC_GND         2'h0
`define AFEPC_SRC_CELL        2'h1
`define AFEPC_SRC_HALF_REF    2'h2
`define AFEPC_SRC_REF_085     2'h3
`define AFEPC_RST_TRIP_SEL    4'h0
`define AFEPC_RST_SRC_SEL     2'h0
`define AFEPC_RST_CELL_SEL    3'h0
`define AFEPC_RST_BLEED       6'h00
`define AFEPC_RST_ENABLES     5'h00
`endif

// >>> hdl/afepc_pkg.sv
package afepc_pkg;
    typedef enum logic [1:0] {
        AFEPC_OFF,
        AFEPC_RUN,
        AFEPC_SLEEP_DRAIN,
        AFEPC_SLEEP_ARMED
    } afepc_state_t;
    typedef struct packed {
        logic cell_xlat_on;
        logic cur_amp_on;
        logic ref_on;
        logic oc_comp_on;
        logic thermistor_bias_on;
    } afepc_enables_t;
    typedef struct packed {
        logic [1:0] cell_out_source_sel;
        logic [2:0] cell_sel;
        logic       temp_sel;
    } afepc_mux_t;
endpackage : afepc_pkg

// >>> hdl/afepc_bleed.sv
`include "afepc_defines.svh"
module afepc_bleed
    import afepc_pkg::*;
#(
    parameter int N = `AFEPC_CELLS
) (
    // Requested bleed bits
    input  wire logic [N-1:0] req_i,
    // Switch drive
    output logic      [N-1:0] sw_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sw
            logic lo_clash;
            logic hi_clash;
            if (g == 0) begin : g_lo0
                assign lo_clash = 1'b0;
            end else begin : g_lo
                assign lo_clash = req_i[g-1];
            end
            if (g == N-1) begin : g_hi0
                assign hi_clash = 1'b0;
            end else begin : g_hi
                assign hi_clash = req_i[g+1];
            end
            assign sw_o[g] = req_i[g] & ~lo_clash & ~hi_clash;
        end
    endgenerate
endmodule : afepc_bleed

// >>> bench/afepc_checker.sv
module afepc_checker
    import afepc_pkg::*;
#(
    parameter int N = 6
) (
    // Clock, reset and watched inputs
    input wire logic           clk_i,
    input wire logic           rst_b_i,
    input wire logic           supply_below_shut_i,
    input wire logic           ctl_we_i,
    input wire logic           sleep_override_i,
    input wire logic           regulator_discharged_i,
    // Watched outputs
    input wire logic [15:0]    oc_trip_mv_o,
    input wire logic           alert_o,
    input wire logic           alert_oe_o,
    input wire logic           alert_status_o,
    input wire logic [N-1:0]   bleed_switch_on_o,
    input wire afepc_enables_t enables_o,
    input wire logic           regulator_on_o,
    input wire logic           regulator_pulldown_o,
    input wire logic           wake_armed_o,
    input wire logic           por_flag_o,
    input wire logic           powered_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_trip;
        oc_trip_mv_o >= 16'h0019 && oc_trip_mv_o <= 16'h0190 && oc_trip_mv_o % 16'h0019 == 16'h0000;
    endproperty
    a_trip: assert property (p_trip) else $error("trip level off grid");
    property p_open; alert_o == 1'b0; endproperty
    a_open: assert property (p_open) else $error("alert pin driven high");
    property p_status; alert_status_o == alert_oe_o; endproperty
    a_status: assert property (p_status) else $error("alert status not live");
    property p_bleed; (bleed_switch_on_o & (bleed_switch_on_o >> 1)) == {N{1'b0}}; endproperty
    a_bleed: assert property (p_bleed) else $error("adjacent bleed switches on");
    property p_en; !powered_o |-> enables_o == 5'h00; endproperty
    a_en: assert property (p_en) else $error("enables on while unpowered");
    property p_sleep; regulator_pulldown_o |-> !regulator_on_o && !powered_o; endproperty
    a_sleep: assert property (p_sleep) else $error("regulator on during sleep");
    property p_arm; $rose(wake_armed_o) |-> $past(regulator_discharged_i, 2); endproperty
    a_arm: assert property (p_arm) else $error("wake armed before discharge");
    property p_ovr;
        powered_o && ctl_we_i && sleep_override_i && !supply_below_shut_i |=> powered_o [*4];
    endproperty
    a_ovr: assert property (p_ovr) else $error("slept despite override");
    // An override exit from draining is not a power-up, so it leaves the flag alone
    property p_por;
        $rose(powered_o) && (!$past(regulator_pulldown_o) || $past(wake_armed_o))
            |-> ##[0:2] por_flag_o;
    endproperty
    a_por: assert property (p_por) else $error("power-on flag not set");
    property p_shut; supply_below_shut_i [*6] |=> !powered_o; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown on low supply");
    c_sleep: cover property ($rose(regulator_pulldown_o));
    c_wake: cover property ($rose(wake_armed_o) ##[1:300] powered_o);
    c_por: cover property ($fell(por_flag_o));
endmodule : afepc_checker
bind afepc_top afepc_checker #(.N(N)) i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .supply_below_shut_i(supply_below_shut_i), .ctl_we_i(ctl_we_i),
    .sleep_override_i(sleep_override_i), .regulator_discharged_i(regulator_discharged_i),
    .oc_trip_mv_o(oc_trip_mv_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
    .alert_status_o(alert_status_o), .bleed_switch_on_o(bleed_switch_on_o),
    .enables_o(enables_o), .regulator_on_o(regulator_on_o),
    .regulator_pulldown_o(regulator_pulldown_o), .wake_armed_o(wake_armed_o),
    .por_flag_o(por_flag_o), .powered_o(powered_o));

// >>> bench/afepc_plant.sv
module afepc_plant (
    // Device side
    input  wire logic clk_i,
    input  wire logic regulator_on_i,
    input  wire logic pulldown_i,
    input  wire logic alert_oe_i,
    input  wire logic wake_pull_i,
    // Analog answers
    output logic      discharged_o,
    output logic      alert_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] drain_ff;
    // Regulator decays slowly, so early override still finds it powered
    always_ff @(posedge clk_i) begin
        if (!pulldown_i) drain_ff <= 5'h00;
        else if (drain_ff != 5'h1f) drain_ff <= drain_ff + 5'h01;
    end
    assign discharged_o = (drain_ff == 5'h1f);
    // Open-drain wire: pull-down wins, else pulled up by regulator or waker
    assign alert_pin_o = !alert_oe_i && (regulator_on_i || wake_pull_i);
endmodule : afepc_plant

// >>> bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import afepc_pkg::*;
    logic clk_i = 0, rst_b_i = 0, supply_above_por_i = 1, supply_below_shut_i = 0;
    logic ctl_we_i = 0, oc_direction_sel_i = 0, sleep_i = 0, sleep_override_i = 0;
    logic [3:0] oc_trip_level_sel_i = 4'h0;
    logic [1:0] cell_out_source_sel_i = 2'h0;
    logic [2:0] cell_sel_i = 3'h0;
    logic [5:0] bleed_control_reg_i = 6'h00;
    logic cell_xlat_on_i = 0, cur_amp_on_i = 0, ref_on_i = 0, oc_comp_on_i = 0;
    logic thermistor_bias_on_i = 0, por_flag_we_i = 0, por_flag_wdata_i = 0;
    logic oc_pos_over_i = 0, oc_neg_over_i = 0, regulator_discharged_i, alert_pin_i;
    logic wake_pull = 0, alert_o, alert_oe_o, alert_status_o, thermistor_bias_out_o;
    logic oc_direction_o, regulator_on_o, regulator_pulldown_o, wake_armed_o;
    logic por_flag_o, powered_o;
    logic [15:0] oc_trip_mv_o;
    afepc_mux_t cell_measure_out_o;
    afepc_enables_t enables_o;
    logic [5:0] bleed_switch_on_o;
    int fails = 0, checked = 0;
    always #2.5 clk_i = ~clk_i;
    afepc_top #(.N(6)) i_dut (.clk_i, .rst_b_i, .supply_above_por_i, .supply_below_shut_i,
        .ctl_we_i, .oc_trip_level_sel_i, .oc_direction_sel_i, .cell_out_source_sel_i,
        .cell_sel_i, .bleed_control_reg_i, .cell_xlat_on_i, .cur_amp_on_i, .ref_on_i,
        .oc_comp_on_i, .thermistor_bias_on_i, .sleep_i, .sleep_override_i, .por_flag_we_i,
        .por_flag_wdata_i, .oc_pos_over_i, .oc_neg_over_i, .regulator_discharged_i,
        .alert_pin_i, .oc_trip_mv_o, .oc_direction_o, .alert_o, .alert_oe_o,
        .alert_status_o, .thermistor_bias_out_o, .cell_measure_out_o, .bleed_switch_on_o,
        .enables_o, .regulator_on_o, .regulator_pulldown_o, .wake_armed_o, .por_flag_o,
        .powered_o);
    afepc_plant i_plant (.clk_i, .regulator_on_i(regulator_on_o),
        .pulldown_i(regulator_pulldown_o), .alert_oe_i(alert_oe_o), .wake_pull_i(wake_pull),
        .discharged_o(regulator_discharged_i), .alert_pin_o(alert_pin_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
        checked++;
        if (ex !== got) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // m = {direction, source, cell, sleep, override}
    task automatic wr(logic [3:0] t, logic [7:0] m, logic [5:0] b, logic [4:0] e);
        @(negedge clk_i);
        oc_trip_level_sel_i = t;
        {oc_direction_sel_i, cell_out_source_sel_i, cell_sel_i, sleep_i, sleep_override_i} = m;
        bleed_control_reg_i = b;
        {cell_xlat_on_i, cur_amp_on_i, ref_on_i, oc_comp_on_i, thermistor_bias_on_i} = e;
        ctl_we_i = 1;
        @(negedge clk_i);
        ctl_we_i = 0;
        repeat (6) @(negedge clk_i);
    endtask : wr
    task automatic wpw(logic v, int lim);
        for (int i = 0; i < lim && powered_o !== v; i++) @(negedge clk_i);
        repeat (3) @(negedge clk_i);
        chk("powered", 16'(v), 16'(powered_o));
    endtask : wpw
    task automatic clr_por();
        @(negedge clk_i);
        por_flag_we_i = 1;
        @(negedge clk_i);
        por_flag_we_i = 0;
        repeat (3) @(negedge clk_i);
    endtask : clr_por
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    logic [11:0] bt [5] = '{12'h555, 12'h0c0, 12'h2c8, 12'hfc0, 12'h861};
    initial begin
        repeat (6) @(negedge clk_i);
        rst_b_i = 1;
        wpw(1, 300);
        chk("por", 16'h1, 16'(por_flag_o));
        chk("trip", 16'h0019, oc_trip_mv_o);
        clr_por();
        chk("por", 16'h0, 16'(por_flag_o));
        $display("test power_up done");
        for (int k = 0; k < 16; k++) begin
            wr(4'(k), {k[0], 7'h00}, 6'h00, 5'h1f);
            chk("trip", 16'(25 + 25 * k), oc_trip_mv_o);
            chk("dir", 16'(k[0]), 16'(oc_direction_o));
        end
        chk("enables", 16'h1f, 16'(enables_o));
        chk("bias", 16'h1, 16'(thermistor_bias_out_o));
        oc_pos_over_i = 1;
        wr(4'h0, 8'h00, 6'h00, 5'h1f);
        chk("alert", 16'h1, 16'(alert_oe_o));
        chk("status", 16'h1, 16'(alert_status_o));
        wr(4'h0, 8'h80, 6'h00, 5'h1f);
        chk("alert", 16'h0, 16'(alert_oe_o));
        oc_neg_over_i = 1;
        repeat (8) @(negedge clk_i);
        chk("alert", 16'h1, 16'(alert_oe_o));
        {oc_pos_over_i, oc_neg_over_i} = 2'h0;
        repeat (8) @(negedge clk_i);
        chk("status", 16'h0, 16'(alert_status_o));
        $display("test overcurrent done");
        for (int s = 0; s < 4; s++) begin
            wr(4'h0, {1'b0, 2'(s), 5'h18}, 6'h00, 5'h00);
            chk("mux", {10'h0, 2'(s), 3'h6, s == 1}, 16'(cell_measure_out_o));
        end
        chk("enables", 16'h0, 16'(enables_o));
        chk("bias", 16'h0, 16'(thermistor_bias_out_o));
        foreach (bt[i]) begin
            wr(4'h0, 8'h00, bt[i][11:6], 5'h00);
            chk("bleed", 16'(bt[i][5:0]), 16'(bleed_switch_on_o));
        end
        $display("test mux_bleed done");
        wr(4'h0, 8'h03, 6'h00, 5'h00);
        chk("powered", 16'h1, 16'(powered_o));
        wr(4'h0, 8'h02, 6'h00, 5'h00);
        chk("reg_on", 16'h0, 16'(regulator_on_o));
        chk("pulldown", 16'h1, 16'(regulator_pulldown_o));
        chk("armed", 16'h0, 16'(wake_armed_o));
        wr(4'h0, 8'h01, 6'h00, 5'h00);
        wpw(1, 40);
        clr_por();
        wr(4'h0, 8'h02, 6'h01, 5'h00);
        repeat (50) @(negedge clk_i);
        chk("armed", 16'h1, 16'(wake_armed_o));
        wake_pull = 1;
        wpw(1, 60);
        wake_pull = 0;
        chk("por", 16'h1, 16'(por_flag_o));
        chk("bleed", 16'h0, 16'(bleed_switch_on_o));
        $display("test sleep done");
        wr(4'h5, 8'h00, 6'h15, 5'h00);
        {supply_below_shut_i, supply_above_por_i} = 2'h2;
        wpw(0, 40);
        {supply_below_shut_i, supply_above_por_i} = 2'h1;
        wpw(1, 40);
        chk("trip", 16'h0019, oc_trip_mv_o);
        chk("bleed", 16'h0, 16'(bleed_switch_on_o));
        $display("test brownout done");
        end_of_test();
    end
    initial begin
        #50us;
        fails++;
        end_of_test();
    end
endmodule : tb_top
